// >>> common/ts0_ctrl_defs.svh
`ifndef TS0_CTRL_DEFS_SVH
`define TS0_CTRL_DEFS_SVH

// ----------------------------------------------------------------------------
// register indices, byte address is four times the index
// ----------------------------------------------------------------------------
`define IDX_DL_SELECT      8'h10
`define IDX_MODE_SELECT    8'h11
`define IDX_NONFRAME_ALIGN_SIGNAL_CONTROL   8'h12

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define RST_DL_SELECT      8'h00
`define RST_MODE_SELECT    8'h00
`define RST_NONFRAME_ALIGN_SIGNAL_CONTROL   8'h9f
`define NONFRAME_ALIGN_SIGNAL_WRITE_MASK    8'hbf

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define BIT_AIS_SEL        7
`define BIT_MF_SEL         6
`define BIT_NAT_BUF        5
`define BIT_TX_INTL_USE_ZERO           7
`define BIT_REMAINDER_MODIFY_ENABLE           6
`define BIT_SOFT_RST       5
`define BIT_AUTO_REMOTE_ALARM_DISABLE           4
`define BIT_AUTO_YBIT_DISABLE           3
`define BIT_MODE           2
`define BIT_CRC_SYNC_DISABLE           1
`define BIT_CRC_INTERWORK_DISABLE           0
`define BIT_TX_INTL_USE_ONE           7
`define BIT_TX_ALARM_BIT           5
`define FAS_LOW_BITS       7'h1b
`define SA4_ONLY           5'h10

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define SYS_CLK_KHZ        125000
`define LINE_RATE_KHZ      2048
`define AIS_WINDOW_BITS    512
`define AIS_ZERO_LIMIT     3
`define BITS_PER_FRAME     256
`define FRAMES_PER_MF      16

`endif

// >>> common/ts0_ctrl_pkg.sv
`default_nettype none
package ts0_ctrl_pkg;

    typedef enum logic {
        BUS_IDLE,
        BUS_RESP
    } bus_state_t;

    typedef struct packed {
        logic basic_sync;
        logic mf_align;
        logic sig_mf_start;
        logic crc_mf_start;
    } rx_status_t;

    typedef struct packed {
        logic       crc_bit;
        logic       si_bit;
        logic       txb_conn;
        logic       txb_bit;
        logic [4:0] dl_bits;
        logic [4:0] nat_buf;
        logic [7:0] backplane_ts0;
    } ts0_src_t;

endpackage
`default_nettype wire

// >>> dv/line_far_end.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------------
// far line end: all ones when asked, else toggling data with zeros
// ----------------------------------------------------------------------------
module line_far_end (
    input  wire logic                      clk_in,     // system clock
    input  wire logic                      ais_in,     // send all ones
    output var  logic                      rx_bit_out = 1'b0, // line bit
    output wire ts0_ctrl_pkg::rx_status_t  status_out  // framer status
);
    always @(posedge clk_in) begin
        rx_bit_out <= ais_in | ~rx_bit_out;
    end
    // basic sync and multiframe alignment held; signalling start held high
    // so the selected pulse path shows a steady level
    assign status_out = 4'he;
endmodule
`default_nettype wire

// >>> dv/ts0_framing_control_test.sv
`timescale 1ns/10ps
`default_nettype none
module ts0_framing_control_test;
    logic                    sys_clk_in = 1'b0;
    logic                    rst_n_in = 1'b0;
    logic [7:0]              adr = 8'h00;
    logic                    rd = 1'b0;
    logic                    wr = 1'b0;
    logic [31:0]             wd = 32'h0;
    logic [31:0]             rdo;
    logic                    wq;
    logic [7:0]              q;
    logic [7:0]              tb;
    logic                    fas;
    logic                    fs;
    logic                    ais;
    logic                    yb;
    logic                    mfp;
    logic                    rxb;
    logic [8:0]              lv;
    ts0_ctrl_pkg::rx_status_t sts;
    int                      n_fail = 0;
    int                      checks_done = 0;
    int                      cyc = 0;
    always #4 sys_clk_in = ~sys_clk_in;
    line_far_end u_far (.clk_in(sys_clk_in), .ais_in(1'b1), .rx_bit_out(rxb), .status_out(sts));
    ts0_framing_control u_dut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
        .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
        .avs_byteenable_in(4'hf), .avs_readdata_out(rdo), .avs_waitrequest_out(wq),
        .rx_bit_in(rxb), .rx_status_in(sts), .ts0_src_in(22'h014000), .manual_ybit_in(1'b1),
        .tx_ts0_byte_out(tb), .tx_fas_frame_out(fas), .tx_frame_start_out(fs),
        .tx_ybit_out(yb), .rx_multiframe_pulse_out(mfp), .ais_detected_out(ais),
        .transparent_out(lv[8]), .remainder_modify_out(lv[7]), .crc_sync_enable_out(lv[6]),
        .crc_interwork_out(lv[5]), .data_link_mask_out(lv[4:0]));
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    always @(posedge sys_clk_in) begin
        cyc++;
        if (cyc == 100000) begin
            n_fail++;
            wrap_up();
        end
    end
    task automatic chk(input string s, input logic [8:0] seen, input logic [8:0] exp);
        checks_done++;
        if (seen !== exp) begin
            $display("Error %s expected %h seen %h", s, exp, seen);
            n_fail++;
        end
    endtask
    // request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_in);
        adr <= a;
        wr <= w;
        rd <= !w;
        wd <= {24'h0, d};
        @(posedge sys_clk_in);
        while (wq !== 1'b0)
            @(posedge sys_clk_in);
        q = rdo[7:0];
        rd <= 1'b0;
        wr <= 1'b0;
        repeat (2) @(negedge sys_clk_in);
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        chk("register", {1'b0, q}, {1'b0, exp});
    endtask
    task automatic frm;
        int n;
        n = 0;
        @(negedge sys_clk_in);
        while (fs !== 1'b1 && n < 20000) begin
            @(negedge sys_clk_in);
            n++;
        end
        if (n == 20000)
            n_fail++;
    endtask
    initial begin
        repeat (10) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        repeat (3) @(posedge sys_clk_in);
        rchk(8'h40, 8'h00);
        rchk(8'h44, 8'h00);
        rchk(8'h48, 8'h9f);
        rchk(8'h4c, 8'h00);
        chk("levels", lv, 9'h060);
        bus(1'b1, 8'h44, 8'h47);
        chk("levels", lv, 9'h190);
        bus(1'b1, 8'h40, 8'h03);
        bus(1'b1, 8'h48, 8'hf5);
        rchk(8'h48, 8'hb5);
        bus(1'b1, 8'h44, 8'h20);
        rchk(8'h44, 8'h20);
        rchk(8'h40, 8'h00);
        rchk(8'h48, 8'h9f);
        chk("levels", lv, 9'h060);
        frm();
        chk("ts0 byte", {1'b0, tb}, 9'h01b);
        chk("y bit", {8'h00, yb}, 9'h000);
        chk("mf pulse", {8'h00, mfp}, 9'h001);
        chk("alarm", {8'h00, ais}, 9'h000);
        frm();
        chk("ts0 byte", {1'b0, tb}, 9'h05f);
        bus(1'b1, 8'h40, 8'h43);
        bus(1'b1, 8'h48, 8'hb5);
        bus(1'b1, 8'h44, 8'h92);
        for (int i = 0; i < 3; i++) begin
            frm();
            chk("ts0 byte", {1'b0, tb}, (i == 1) ? 9'h0f6 : 9'h09b);
            chk("frame type", {8'h00, fas}, (i == 1) ? 9'h000 : 9'h001);
        end
        chk("mf pulse", {8'h00, mfp}, 9'h000);
        chk("alarm", {8'h00, ais}, 9'h001);
        wrap_up();
    end
endmodule
`default_nettype wire

// >>> hw/ais_detector.sv
`timescale 1ns/10ps
`default_nettype none
`include "ts0_ctrl_defs.svh"
module ais_detector (
    input  wire logic clk_in,      // system clock
    input  wire logic rst_n_in,    // synchronised reset
    input  wire logic clr_in,      // soft reset pulse
    input  wire logic bit_en_in,   // one line bit
    input  wire logic rx_bit_in,   // received bit
    input  wire logic two_win_in,  // two-window criterion
    output logic      ais_out      // alarm indication detected
);
    logic [8:0] bit_pos;
    logic [1:0] zeros;
    logic       prev_ok;
    wire        win_end = bit_en_in && (bit_pos == 9'(`AIS_WINDOW_BITS - 1));
    wire  [1:0] zeros_now = (!rx_bit_in && zeros != 2'(`AIS_ZERO_LIMIT)) ? zeros + 2'h1 : zeros;
    wire        win_ok = zeros_now < 2'(`AIS_ZERO_LIMIT);

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            bit_pos <= 9'h000;
            zeros   <= 2'h0;
            prev_ok <= 1'b0;
            ais_out <= 1'b0;
        end else if (clr_in) begin
            bit_pos <= 9'h000;
            zeros   <= 2'h0;
            prev_ok <= 1'b0;
            ais_out <= 1'b0;
        end else if (bit_en_in) begin
            bit_pos <= bit_pos + 9'h001;
            zeros   <= win_end ? 2'h0 : zeros_now;
            if (win_end) begin
                prev_ok <= win_ok;
                ais_out <= two_win_in ? (win_ok && prev_ok) : win_ok;
            end
        end
    end

    ais_single_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (win_end && !clr_in && !two_win_in) |=> (ais_out == $past(win_ok)))
        else $error("single window ais verdict wrong");
    ais_double_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (win_end && !clr_in && two_win_in && !prev_ok) |=> !ais_out)
        else $error("double window ais declared after one window");
endmodule
`default_nettype wire

// >>> hw/ts0_bit_builder.sv
`timescale 1ns/10ps
`default_nettype none
`include "ts0_ctrl_defs.svh"
module ts0_bit_builder (
    input  wire logic                  fas_frame_in,    // frame alignment frame
    input  wire logic [7:0]            dl_select_in,    // select register
    input  wire logic [7:0]            mode_in,         // mode register
    input  wire logic [7:0]            nonframe_align_signal_in,         // nonframe_align_signal control register
    input  wire logic                  basic_sync_in,   // basic sync acquired
    input  wire ts0_ctrl_pkg::ts0_src_t src_in,          // bit sources
    output logic [7:0]                 ts0_byte_out     // byte, msb is bit one
);
    wire       transparent = mode_in[`BIT_MODE];
    wire       crc_on = !mode_in[`BIT_CRC_SYNC_DISABLE];
    wire [4:0] dl_mask = transparent ? `SA4_ONLY : dl_select_in[4:0];
    wire [4:0] nat_src = dl_select_in[`BIT_NAT_BUF] ? src_in.nat_buf : nonframe_align_signal_in[4:0];
    wire [4:0] sa_bits = (dl_mask & src_in.dl_bits) | (~dl_mask & nat_src);
    wire       remote_alarm_bit = mode_in[`BIT_AUTO_REMOTE_ALARM_DISABLE] ? nonframe_align_signal_in[`BIT_TX_ALARM_BIT] : !basic_sync_in;
    wire       fas_b1 = crc_on ? src_in.crc_bit : mode_in[`BIT_TX_INTL_USE_ZERO];
    wire       nonframe_align_signal_b1 = crc_on ? src_in.si_bit :
                         (src_in.txb_conn ? src_in.txb_bit : nonframe_align_signal_in[`BIT_TX_INTL_USE_ONE]);
    wire [7:0] term_byte = fas_frame_in ? {fas_b1, `FAS_LOW_BITS}
                                        : {nonframe_align_signal_b1, 1'b1, remote_alarm_bit, sa_bits};
    // transparent keeps backplane ts0, link bit swapped in
    wire [7:0] pass_byte = fas_frame_in ? src_in.backplane_ts0
                         : {src_in.backplane_ts0[7:5],
                            (dl_mask & src_in.dl_bits) | (~dl_mask & src_in.backplane_ts0[4:0])};

    assign ts0_byte_out = transparent ? pass_byte : term_byte;
endmodule
`default_nettype wire

// >>> hw/ts0_framing_control.sv
// Our own choice: register access over Avalon-MM.
`timescale 1ns/10ps
`default_nettype none
`include "ts0_ctrl_defs.svh"
module ts0_framing_control (
    input  wire logic                    sys_clk_in,           // 125 MHz clock
    input  wire logic                    rst_n_in,             // async reset, active low
    input  wire logic [7:0]              avs_address_in,       // byte address
    input  wire logic                    avs_read_in,          // read request
    input  wire logic                    avs_write_in,         // write request
    input  wire logic [31:0]             avs_writedata_in,     // write data
    input  wire logic [3:0]              avs_byteenable_in,    // byte lanes
    output logic [31:0]                  avs_readdata_out,     // read data
    output logic                         avs_waitrequest_out,  // stall
    input  wire logic                    rx_bit_in,            // received line bit
    input  wire ts0_ctrl_pkg::rx_status_t rx_status_in,         // receive framer status
    input  wire ts0_ctrl_pkg::ts0_src_t   ts0_src_in,           // transmit ts0 sources
    input  wire logic                    manual_ybit_in,       // programmed y bit
    output logic [7:0]                   tx_ts0_byte_out,      // ts0 byte, msb first
    output logic                         tx_fas_frame_out,     // current frame is fas
    output logic                         tx_frame_start_out,   // frame start pulse
    output logic                         tx_ybit_out,          // ts16 frame zero y bit
    output logic                         rx_multiframe_pulse_out, // receive mf pulse
    output logic                         ais_detected_out,     // alarm indication seen
    output logic                         transparent_out,      // transparent mode
    output logic                         remainder_modify_out, // crc remainder update
    output logic                         crc_sync_enable_out,  // crc-4 sync running
    output logic                         crc_interwork_out,    // interworking on
    output logic [4:0]                   data_link_mask_out    // national bits on link
);
    // ------------------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------------------
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    function automatic logic [7:0] byte_addr(input logic [7:0] idx);
        byte_addr = 8'(idx << 2);
    endfunction

    // ------------------------------------------------------------------------
    // avalon slave
    // ------------------------------------------------------------------------
    ts0_ctrl_pkg::bus_state_t state;
    ts0_ctrl_pkg::bus_state_t next_state;
    logic [7:0] multiframe_and_dl_select;
    logic [7:0] mode_selection_control;
    logic [7:0] tx_nonframe_align_control;
    logic       soft_rst;

    wire request  = avs_read_in || avs_write_in;
    wire hit_dl   = avs_address_in == byte_addr(`IDX_DL_SELECT);
    wire hit_mode = avs_address_in == byte_addr(`IDX_MODE_SELECT);
    wire hit_nonframe_align_signal = avs_address_in == byte_addr(`IDX_NONFRAME_ALIGN_SIGNAL_CONTROL);
    // a write lands only at the edge where waitrequest is seen low
    wire wr_fire  = (state == ts0_ctrl_pkg::BUS_RESP) && avs_write_in && avs_byteenable_in[0];
    wire [7:0] wr_byte = avs_writedata_in[7:0];
    wire [7:0] rd_byte = hit_dl   ? multiframe_and_dl_select :
                         hit_mode ? mode_selection_control :
                         hit_nonframe_align_signal ? tx_nonframe_align_control : 8'h00;
    wire soft_rst_edge = wr_fire && hit_mode && wr_byte[`BIT_SOFT_RST]
                         && !mode_selection_control[`BIT_SOFT_RST];

    always_comb begin
        next_state = state;
        case (state)
            ts0_ctrl_pkg::BUS_IDLE: begin
                if (request) begin
                    next_state = ts0_ctrl_pkg::BUS_RESP;
                end
            end
            ts0_ctrl_pkg::BUS_RESP: begin
                next_state = ts0_ctrl_pkg::BUS_IDLE;
            end
            default: begin
                next_state = ts0_ctrl_pkg::BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            state               <= ts0_ctrl_pkg::BUS_IDLE;
            avs_waitrequest_out <= 1'b1;
            avs_readdata_out    <= 32'h0000_0000;
        end else begin
            state               <= next_state;
            avs_waitrequest_out <= next_state != ts0_ctrl_pkg::BUS_RESP;
            if (state == ts0_ctrl_pkg::BUS_IDLE && avs_read_in) begin
                avs_readdata_out <= {24'h00_0000, rd_byte};
            end
        end
    end

    // ------------------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------------------
    // the soft reset bit itself keeps what was written, so only a new
    // low-to-high write can fire another reset
    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            multiframe_and_dl_select  <= `RST_DL_SELECT;
            mode_selection_control    <= `RST_MODE_SELECT;
            tx_nonframe_align_control <= `RST_NONFRAME_ALIGN_SIGNAL_CONTROL;
            soft_rst                  <= 1'b0;
        end else begin
            soft_rst <= soft_rst_edge;
            if (soft_rst) begin
                multiframe_and_dl_select  <= `RST_DL_SELECT;
                mode_selection_control    <= (`RST_MODE_SELECT & ~(8'h01 << `BIT_SOFT_RST))
                                             | (mode_selection_control & (8'h01 << `BIT_SOFT_RST));
                tx_nonframe_align_control <= `RST_NONFRAME_ALIGN_SIGNAL_CONTROL;
            end else if (wr_fire) begin
                if (hit_dl) begin
                    multiframe_and_dl_select <= wr_byte;
                end
                if (hit_mode) begin
                    mode_selection_control <= wr_byte;
                end
                if (hit_nonframe_align_signal) begin
                    tx_nonframe_align_control <= wr_byte & `NONFRAME_ALIGN_SIGNAL_WRITE_MASK;
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // line bit rate
    // ------------------------------------------------------------------------
    // fractional accumulator gives the exact average rate; bit edges jitter
    // by one system clock, which the framer downstream tolerates
    logic [16:0] rate_acc;
    logic        bit_en;
    wire  [17:0] acc_sum  = {1'b0, rate_acc} + 18'(`LINE_RATE_KHZ);
    wire         acc_wrap = acc_sum >= 18'(`SYS_CLK_KHZ);

    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            rate_acc <= 17'h00000;
            bit_en   <= 1'b0;
        end else begin
            rate_acc <= acc_wrap ? 17'(acc_sum - 18'(`SYS_CLK_KHZ)) : acc_sum[16:0];
            bit_en   <= acc_wrap;
        end
    end

    // ------------------------------------------------------------------------
    // frame timing and transmit overhead
    // ------------------------------------------------------------------------
    logic [7:0] bit_cnt;
    logic [3:0] frame_cnt;
    wire        frame_edge = bit_en && (bit_cnt == 8'(`BITS_PER_FRAME - 1));
    wire  [3:0] next_frame = frame_cnt + 4'h1;
    wire        next_fas = !next_frame[0];
    wire  [7:0] built_byte;
    wire        ybit_value = mode_selection_control[`BIT_AUTO_YBIT_DISABLE] ? manual_ybit_in
                                                               : !rx_status_in.mf_align;

    ts0_bit_builder builder (
        .fas_frame_in  (next_fas),
        .dl_select_in  (multiframe_and_dl_select),
        .mode_in       (mode_selection_control),
        .nonframe_align_signal_in       (tx_nonframe_align_control),
        .basic_sync_in (rx_status_in.basic_sync),
        .src_in        (ts0_src_in),
        .ts0_byte_out  (built_byte)
    );

    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt            <= 8'h00;
            frame_cnt          <= 4'hf;
            tx_ts0_byte_out    <= 8'h00;
            tx_fas_frame_out   <= 1'b0;
            tx_frame_start_out <= 1'b0;
            tx_ybit_out        <= 1'b1;
        end else begin
            tx_frame_start_out <= frame_edge;
            if (bit_en) begin
                bit_cnt <= bit_cnt + 8'h01;
            end
            if (frame_edge) begin
                frame_cnt        <= next_frame;
                tx_ts0_byte_out  <= built_byte;
                tx_fas_frame_out <= next_fas;
                if (next_frame == 4'h0) begin
                    tx_ybit_out <= ybit_value;
                end
            end
        end
    end

    // ------------------------------------------------------------------------
    // receive side and mode outputs
    // ------------------------------------------------------------------------
    logic ais_raw;

    ais_detector ais_det (
        .clk_in     (sys_clk_in),
        .rst_n_in   (rst_n),
        .clr_in     (soft_rst),
        .bit_en_in  (bit_en),
        .rx_bit_in  (rx_bit_in),
        .two_win_in (multiframe_and_dl_select[`BIT_AIS_SEL]),
        .ais_out    (ais_raw)
    );

    wire transparent = mode_selection_control[`BIT_MODE];
    wire mf_pulse = multiframe_and_dl_select[`BIT_MF_SEL] ? rx_status_in.crc_mf_start
                                                          : rx_status_in.sig_mf_start;

    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            rx_multiframe_pulse_out <= 1'b0;
            ais_detected_out        <= 1'b0;
            transparent_out         <= 1'b0;
            remainder_modify_out    <= 1'b0;
            crc_sync_enable_out     <= 1'b1;
            crc_interwork_out       <= 1'b1;
            data_link_mask_out      <= 5'h00;
        end else begin
            rx_multiframe_pulse_out <= mf_pulse;
            ais_detected_out        <= ais_raw;
            transparent_out         <= transparent;
            remainder_modify_out    <= transparent && mode_selection_control[`BIT_REMAINDER_MODIFY_ENABLE];
            crc_sync_enable_out     <= !mode_selection_control[`BIT_CRC_SYNC_DISABLE];
            crc_interwork_out       <= !mode_selection_control[`BIT_CRC_INTERWORK_DISABLE];
            data_link_mask_out      <= transparent ? `SA4_ONLY : multiframe_and_dl_select[4:0];
        end
    end

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    mf_pulse_sel_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        multiframe_and_dl_select[`BIT_MF_SEL] && $stable(multiframe_and_dl_select)
        |=> rx_multiframe_pulse_out == $past(rx_status_in.crc_mf_start))
        else $error("multiframe pulse not aligned to crc multiframe");
    soft_reset_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        soft_rst_edge |-> ##2 (multiframe_and_dl_select == `RST_DL_SELECT
        && tx_nonframe_align_control == `RST_NONFRAME_ALIGN_SIGNAL_CONTROL))
        else $error("soft reset did not restore defaults");
    frame_alt_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        tx_frame_start_out |-> tx_fas_frame_out != $past(tx_fas_frame_out))
        else $error("fas and nonframe_align_signal frames did not alternate");
    fas_word_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        (tx_frame_start_out && tx_fas_frame_out && !transparent_out)
        |-> tx_ts0_byte_out[6:0] == `FAS_LOW_BITS)
        else $error("fas word wrong in termination mode");
    auto_rai_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        (frame_edge && !next_fas && !transparent
        && !mode_selection_control[`BIT_AUTO_REMOTE_ALARM_DISABLE] && rx_status_in.basic_sync)
        |=> !tx_ts0_byte_out[5])
        else $error("remote alarm sent while basic sync held");
    manual_alarm_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        (frame_edge && !next_fas && !transparent && mode_selection_control[`BIT_AUTO_REMOTE_ALARM_DISABLE])
        |=> tx_ts0_byte_out[5] == $past(tx_nonframe_align_control[`BIT_TX_ALARM_BIT]))
        else $error("transmit alarm bit not placed");
    auto_ybit_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        (frame_edge && next_frame == 4'h0 && !mode_selection_control[`BIT_AUTO_YBIT_DISABLE])
        |=> tx_ybit_out == !$past(rx_status_in.mf_align))
        else $error("automatic y bit wrong");
    national_field_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        (frame_edge && !next_fas && !transparent && multiframe_and_dl_select == 8'h00)
        |=> tx_ts0_byte_out[4:0] == $past(tx_nonframe_align_control[4:0]))
        else $error("national field not transmitted");
    tiu_one_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        (frame_edge && !next_fas && !transparent && mode_selection_control[`BIT_CRC_SYNC_DISABLE]
        && !ts0_src_in.txb_conn)
        |=> tx_ts0_byte_out[7] == $past(tx_nonframe_align_control[`BIT_TX_INTL_USE_ONE]))
        else $error("international one bit not transmitted");
    bus_answer_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        (state == ts0_ctrl_pkg::BUS_IDLE && request) |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
        else $error("bus answer not one cycle after request");
    mf_pulse_sig_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        !multiframe_and_dl_select[`BIT_MF_SEL] && $stable(multiframe_and_dl_select)
        |=> rx_multiframe_pulse_out == $past(rx_status_in.sig_mf_start))
        else $error("multiframe pulse not aligned to signalling multiframe");
    mode_level_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        transparent_out == $past(mode_selection_control[`BIT_MODE]))
        else $error("transmit mode level wrong");
    crc_sync_level_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        crc_sync_enable_out != $past(mode_selection_control[`BIT_CRC_SYNC_DISABLE]))
        else $error("crc sync enable level wrong");
    interwork_level_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        crc_interwork_out != $past(mode_selection_control[`BIT_CRC_INTERWORK_DISABLE]))
        else $error("interworking level wrong");
    sa4_link_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        transparent_out |-> data_link_mask_out == `SA4_ONLY)
        else $error("transparent link not on sa4");
    remainder_mode_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        remainder_modify_out |-> transparent_out)
        else $error("remainder modification outside transparent mode");
    ybit_frame_zero_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        $changed(tx_ybit_out) |-> $past(frame_edge) && $past(frame_cnt) == 4'hf)
        else $error("y bit changed outside frame zero");
endmodule
`default_nettype wire
